//--- hw/teu_consts.svh
`ifndef TEU_CONSTS_SVH
`define TEU_CONSTS_SVH

// Fixed virtual address at which every trap handler starts.
`define TEU_HANDLER_VEC 32'hFFFF_FF00
// Byte distance from the floating-point half of a pair to its core half.
`define TEU_CORE_HALF_OFS 32'h0000_0004
// Reset value for the two fault address registers.
`define TEU_ADDR_RST 32'h0000_0000
// Largest instruction count from lock to the closing access.
`define TEU_LOCK_LIMIT 5'h1E
// Width of the lock instruction counter.
`define TEU_LOCK_CNT_W 5
// Counter start and step values.
`define TEU_LOCK_CNT_RST 5'h00
`define TEU_LOCK_CNT_ONE 5'h01
// Number of pins passed through the input synchroniser.
`define TEU_PIN_CNT 3
// Bit positions of the synchronised pins.
`define TEU_PIN_BUS_ERROR_INPUT 0
`define TEU_PIN_INTR 1
`define TEU_PIN_PAREN 2

`endif

//--- hw/teu_lock_watch.sv
`timescale 1ns/10ps
`include "teu_consts.svh"

module teu_lock_watch
  import teu_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic instr_done,
  input wire logic op_lock,
  input wire logic op_unlock,
  input wire logic op_ldst,
  input wire logic trap_abort,
  output logic violation
);

  teu_lock_state_type state_ff;
  teu_lock_state_type nxt_state;
  logic [`TEU_LOCK_CNT_W-1:0] count_ff;
  logic [`TEU_LOCK_CNT_W-1:0] nxt_count;
  logic open_seq;

  assign open_seq = (state_ff != teu_lk_idle);

  // The sequence is broken when the closing access has not come by the limit count.
  assign violation = open_seq && instr_done && (count_ff >= `TEU_LOCK_LIMIT) &&
                     !((state_ff == teu_lk_wait_last) && op_ldst);

  // Walk lock, first access, unlock, closing access.
  always_comb begin
    nxt_state = state_ff;
    nxt_count = count_ff;
    if (trap_abort) begin
      nxt_state = teu_lk_idle;
      nxt_count = `TEU_LOCK_CNT_RST;
    end else if (instr_done) begin
      if (open_seq) begin
        nxt_count = count_ff + `TEU_LOCK_CNT_ONE;
      end
      case (state_ff)
        teu_lk_idle: begin
          if (op_lock) begin
            nxt_state = teu_lk_wait_first;
            nxt_count = `TEU_LOCK_CNT_RST;
          end
        end
        teu_lk_wait_first: begin
          if (op_ldst) begin
            nxt_state = teu_lk_wait_unlock;
          end
        end
        teu_lk_wait_unlock: begin
          if (op_unlock) begin
            nxt_state = teu_lk_wait_last;
          end
        end
        teu_lk_wait_last: begin
          if (op_ldst) begin
            nxt_state = teu_lk_idle;
            nxt_count = `TEU_LOCK_CNT_RST;
          end
        end
        default: begin
          nxt_state = teu_lk_idle;
        end
      endcase
    end
  end

  // Sequence state and counter advance together with each completed instruction.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= teu_lk_idle;
      count_ff <= `TEU_LOCK_CNT_RST;
    end else begin
      state_ff <= nxt_state;
      count_ff <= nxt_count;
    end
  end

endmodule : teu_lock_watch

//--- hw/teu_pin_sync.sv
`timescale 1ns/10ps
`include "teu_consts.svh"

module teu_pin_sync
  import teu_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [`TEU_PIN_CNT-1:0] pin_raw,
  output logic [`TEU_PIN_CNT-1:0] pin_stable_ff
);

  logic [`TEU_PIN_CNT-1:0] meta_ff;
  logic [`TEU_PIN_CNT-1:0] sync2_ff;
  logic [`TEU_PIN_CNT-1:0] sync3_ff;

  // Three-stage chain; only the second and third stages feed the agreement check.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      meta_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
    end else begin
      meta_ff <= pin_raw;
      sync2_ff <= meta_ff;
      sync3_ff <= sync2_ff;
    end
  end

  // A pin counts as changed only once two settled stages agree, filtering one-cycle glitches.
  genvar gi;
  generate
    for (gi = 0; gi < `TEU_PIN_CNT; gi = gi + 1) begin : g_pin
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          pin_stable_ff[gi] <= 1'b0;
        end else if (sync2_ff[gi] == sync3_ff[gi]) begin
          pin_stable_ff[gi] <= sync3_ff[gi];
        end
      end
    end
  endgenerate

endmodule : teu_pin_sync

//--- hw/teu_pkg.sv
package teu_pkg;

  // Class of the floating-point operation issued with the current instruction.
  typedef enum logic [2:0] {
    teu_fp_none,
    teu_fp_mult,
    teu_fp_add,
    teu_fp_fmlow,
    teu_fp_pfgt,
    teu_fp_pfeq,
    teu_fp_other
  } teu_fpop_type;

  // Mode and trap-type bits of the processor status register.
  typedef struct packed {
    logic user_flag;
    logic intr_mode_flag;
    logic prev_user_flag;
    logic prev_intr_flag;
    logic dual_mode_at_trap;
    logic dual_switch_flag;
    logic instr_fault_flag;
    logic ext_intr_flag;
    logic fetch_xlate_fault_flag;
    logic data_access_fault_flag;
    logic fp_fault_flag;
  } teu_psr_type;

  // Trap-type bits of the extended status register.
  typedef struct packed {
    logic overflow_flag;
    logic lock_violation_flag;
    logic pipe_in_use_flag;
    logic pipe_trap_flag;
    logic bus_error_flag;
    logic parity_error_flag;
  } teu_epsr_type;

  // Exception bits of the floating-point status register.
  typedef struct packed {
    logic source_exc_flag;
    logic adder_overflow_flag;
    logic mult_overflow_flag;
    logic adder_underflow_flag;
    logic mult_underflow_flag;
    logic adder_inexact_flag;
    logic mult_inexact_flag;
  } teu_fsr_type;

  // State of the instruction now executing, as the pipeline presents it.
  typedef struct packed {
    logic valid;
    logic [31:0] pc;
    logic dual_mode;
    logic next_dual;
    logic op_trap;
    logic op_intovr;
    logic op_lock;
    logic op_unlock;
    logic op_ldst;
    logic uses_pipe;
    logic pipelined;
    teu_fpop_type fp_op;
    logic fp_is_fxfr;
    logic src_exc;
    teu_fsr_type res_exc;
    logic fetch_fault;
    logic data_fault;
    logic int_ovf_set;
  } teu_exec_type;

  // States of the lock sequence watcher.
  typedef enum logic [1:0] {
    teu_lk_idle,
    teu_lk_wait_first,
    teu_lk_wait_unlock,
    teu_lk_wait_last
  } teu_lock_state_type;

endpackage : teu_pkg

//--- hw/teu_trap_entry.sv
// What this block does
// - Abort current instruction; bus/parity traps unrestartable.
// - Save user and interrupt mode into previous flags.
// - Clear user and interrupt mode at entry.
// - Record whether trap hit in dual mode.
// - Record pending switch between single and dual.
// - Set every present cause flag together.
// - Fault address is instruction or floating half.
// - Fetch/data fault in dual: core half is plus four.
// - Lone data fault in dual completes floating half, or squashes it for an fxfr.
// - Vector fetch to the fixed handler address.
// - Handler always starts in single-instruction mode.
// - Instruction-fault causes set the instruction-fault flag.
// - Trap instruction in dual squashes floating companion.
// - Overflow-trap instruction traps only when overflow set.
// - Overflow trap in dual completes floating companion unless it faults too.
// - Lock protocol violation sets lock-violation flag.
// - Pipe use while pipe-trap set faults, sets flags.
// - Exceptional operand faults, except multiply-low.
// - Separate result exceptions, except low, compares.
// - Parity error with enable pin gives trap.
// - Bus-error pin gives bus-error trap.
// - External interrupt pin gives interrupt trap.
// - Closing access beyond thirty instructions faults.
`timescale 1ns/10ps
`include "teu_consts.svh"

module teu_trap_entry
  import teu_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire teu_exec_type exec,
  input wire logic fp_trap_en,
  input wire logic bus_read_parity_err,
  input wire logic parity_enable_input,
  input wire logic bus_error_input,
  input wire logic ext_intr_input,
  input wire logic sw_psr_wr,
  input wire teu_psr_type sw_psr_data,
  input wire logic sw_epsr_wr,
  input wire teu_epsr_type sw_epsr_data,
  input wire logic sw_fsr_wr,
  input wire teu_fsr_type sw_fsr_data,
  output teu_psr_type psr_ff,
  output teu_epsr_type epsr_ff,
  output teu_fsr_type fsr_ff,
  output logic [31:0] fir_ff,
  output logic [31:0] core_fault_addr_ff,
  output logic trap_taken_ff,
  output logic restartable_ff,
  output logic [31:0] fetch_vector_ff,
  output logic force_single_ff,
  output logic fp_half_commit_ff,
  output logic fp_half_squash_ff
);

  logic [`TEU_PIN_CNT-1:0] pin_raw;
  logic [`TEU_PIN_CNT-1:0] pin_stable;
  logic bus_error_input_pin;
  logic intr_pin;
  logic paren_pin;
  logic lock_viol;
  logic instr_done;
  logic cause_trap_instr;
  logic cause_intovr;
  logic cause_pipe;
  logic cause_lock;
  logic cause_instr;
  logic cause_src_exc;
  logic cause_res_exc;
  logic cause_fp;
  logic cause_fetch;
  logic cause_data;
  logic cause_parity;
  logic cause_bus_error_input;
  logic cause_intr;
  logic cause_any;
  logic nxt_restartable;
  logic nxt_commit;
  logic nxt_squash;
  teu_fsr_type res_seen;
  teu_psr_type psr_set;
  teu_epsr_type epsr_set;
  teu_fsr_type fsr_set;

  // Returns whether a floating operation belongs to the multiplier or adder units.
  function automatic logic is_unit_op(input teu_fpop_type op);
    is_unit_op = (op == teu_fp_mult) || (op == teu_fp_add) || (op == teu_fp_fmlow) ||
                 (op == teu_fp_pfgt) || (op == teu_fp_pfeq);
  endfunction : is_unit_op

  // Pins from outside the core clock go through the three-stage filter.
  assign pin_raw[`TEU_PIN_BUS_ERROR_INPUT] = bus_error_input;
  assign pin_raw[`TEU_PIN_INTR] = ext_intr_input;
  assign pin_raw[`TEU_PIN_PAREN] = parity_enable_input;

  teu_pin_sync u_pin_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .pin_raw(pin_raw),
    .pin_stable_ff(pin_stable)
  );

  assign bus_error_input_pin = pin_stable[`TEU_PIN_BUS_ERROR_INPUT];
  assign intr_pin = pin_stable[`TEU_PIN_INTR];
  assign paren_pin = pin_stable[`TEU_PIN_PAREN];

  assign instr_done = exec.valid;

  // The watcher counts completed instructions from lock to the closing access.
  teu_lock_watch u_lock_watch (
    .core_clk(core_clk),
    .nrst(nrst),
    .instr_done(instr_done),
    .op_lock(exec.op_lock),
    .op_unlock(exec.op_unlock),
    .op_ldst(exec.op_ldst),
    .trap_abort(cause_any),
    .violation(lock_viol)
  );

  // Instruction-fault causes, each qualified by a valid executing instruction.
  assign cause_trap_instr = instr_done && exec.op_trap;
  assign cause_intovr = instr_done && exec.op_intovr && epsr_ff.overflow_flag;
  assign cause_pipe = instr_done && exec.uses_pipe && epsr_ff.pipe_trap_flag;
  assign cause_lock = lock_viol;
  assign cause_instr = cause_trap_instr || cause_intovr || cause_pipe || cause_lock;

  // Source exceptions apply to every unit operation but multiply-low.
  assign cause_src_exc = instr_done && exec.src_exc && is_unit_op(exec.fp_op) &&
                         (exec.fp_op != teu_fp_fmlow);

  // Result exceptions are masked for multiply-low and the two compares.
  always_comb begin
    res_seen = '0;
    if (instr_done && fp_trap_en && is_unit_op(exec.fp_op) && (exec.fp_op != teu_fp_fmlow) &&
        (exec.fp_op != teu_fp_pfgt) && (exec.fp_op != teu_fp_pfeq)) begin
      res_seen = exec.res_exc;
    end
  end

  assign cause_res_exc = |res_seen;
  assign cause_fp = cause_src_exc || cause_res_exc;

  // Access faults come straight from translation and alignment checks.
  assign cause_fetch = instr_done && exec.fetch_fault;
  assign cause_data = instr_done && exec.data_fault;

  // External causes; the interrupt pin is ignored while interrupts are disabled.
  assign cause_parity = bus_read_parity_err && paren_pin;
  assign cause_bus_error_input = bus_error_input_pin;
  assign cause_intr = intr_pin && psr_ff.intr_mode_flag;

  assign cause_any = cause_instr || cause_fp || cause_fetch || cause_data ||
                     cause_parity || cause_bus_error_input || cause_intr;

  // Collect the cause flags for all three status registers in one pass.
  always_comb begin
    psr_set = '0;
    epsr_set = '0;
    fsr_set = '0;
    psr_set.instr_fault_flag = cause_instr;
    psr_set.fp_fault_flag = cause_fp;
    psr_set.fetch_xlate_fault_flag = cause_fetch;
    psr_set.data_access_fault_flag = cause_data;
    psr_set.ext_intr_flag = cause_parity || cause_bus_error_input || cause_intr;
    epsr_set.lock_violation_flag = cause_lock;
    epsr_set.pipe_trap_flag = cause_pipe;
    epsr_set.pipe_in_use_flag = cause_pipe || (instr_done && exec.pipelined && !cause_any);
    epsr_set.overflow_flag = instr_done && exec.int_ovf_set && !cause_any;
    epsr_set.bus_error_flag = cause_bus_error_input;
    epsr_set.parity_error_flag = cause_parity;
    fsr_set = res_seen;
    fsr_set.source_exc_flag = cause_src_exc;
  end

  // Mode and trap-type bits; a hardware set wins over a software write in the same cycle.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      psr_ff <= '0;
    end else if (cause_any) begin
      psr_ff.prev_user_flag <= psr_ff.user_flag;
      psr_ff.prev_intr_flag <= psr_ff.intr_mode_flag;
      psr_ff.user_flag <= 1'b0;
      psr_ff.intr_mode_flag <= 1'b0;
      psr_ff.dual_mode_at_trap <= exec.dual_mode;
      psr_ff.dual_switch_flag <= exec.dual_mode ^ exec.next_dual;
      psr_ff.instr_fault_flag <= (sw_psr_wr ? sw_psr_data.instr_fault_flag : psr_ff.instr_fault_flag) |
                                 psr_set.instr_fault_flag;
      psr_ff.ext_intr_flag <= (sw_psr_wr ? sw_psr_data.ext_intr_flag : psr_ff.ext_intr_flag) |
                              psr_set.ext_intr_flag;
      psr_ff.fetch_xlate_fault_flag <= (sw_psr_wr ? sw_psr_data.fetch_xlate_fault_flag :
                                        psr_ff.fetch_xlate_fault_flag) | psr_set.fetch_xlate_fault_flag;
      psr_ff.data_access_fault_flag <= (sw_psr_wr ? sw_psr_data.data_access_fault_flag :
                                        psr_ff.data_access_fault_flag) | psr_set.data_access_fault_flag;
      psr_ff.fp_fault_flag <= (sw_psr_wr ? sw_psr_data.fp_fault_flag : psr_ff.fp_fault_flag) |
                              psr_set.fp_fault_flag;
    end else if (sw_psr_wr) begin
      psr_ff <= sw_psr_data;
    end
  end

  // Extended status; software writes merge with bits hardware sets this cycle.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      epsr_ff <= '0;
    end else begin
      epsr_ff <= (sw_epsr_wr ? sw_epsr_data : epsr_ff) | epsr_set;
    end
  end

  // Floating exception bits follow the same set-over-write merge.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fsr_ff <= '0;
    end else begin
      fsr_ff <= (sw_fsr_wr ? sw_fsr_data : fsr_ff) | fsr_set;
    end
  end

  // Pair addresses point at the floating half, which is the lower aligned word.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fir_ff <= `TEU_ADDR_RST;
      core_fault_addr_ff <= `TEU_ADDR_RST;
    end else if (cause_any) begin
      fir_ff <= exec.pc;
      if (exec.dual_mode && (cause_fetch || cause_data)) begin
        core_fault_addr_ff <= exec.pc + `TEU_CORE_HALF_OFS;
      end else begin
        core_fault_addr_ff <= exec.pc;
      end
    end
  end

  // Fate of the floating half of a pair when the trap is taken.
  always_comb begin
    nxt_commit = 1'b0;
    nxt_squash = 1'b0;
    if (exec.dual_mode) begin
      if (cause_trap_instr) begin
        nxt_squash = 1'b1;
      end else if (cause_intovr && !cause_fp) begin
        nxt_commit = 1'b1;
      end else if (cause_data && !(cause_instr || cause_fp || cause_fetch || cause_parity ||
                                   cause_bus_error_input || cause_intr)) begin
        nxt_commit = !exec.fp_is_fxfr;
        nxt_squash = exec.fp_is_fxfr;
      end else begin
        nxt_squash = 1'b1;
      end
    end
  end

  // Bus and parity errors leave the aborted instruction in an unknown state.
  assign nxt_restartable = !(cause_bus_error_input || cause_parity);

  // Redirect strobes are one-cycle pulses issued on the same edge as the status update.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      trap_taken_ff <= 1'b0;
      restartable_ff <= 1'b1;
      force_single_ff <= 1'b0;
      fp_half_commit_ff <= 1'b0;
      fp_half_squash_ff <= 1'b0;
    end else begin
      trap_taken_ff <= cause_any;
      force_single_ff <= cause_any;
      fp_half_commit_ff <= cause_any && nxt_commit;
      fp_half_squash_ff <= cause_any && nxt_squash;
      if (cause_any) begin
        restartable_ff <= nxt_restartable;
      end
    end
  end

  // The handler address is constant, but held in a flop so the output stays registered.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fetch_vector_ff <= `TEU_HANDLER_VEC;
    end else begin
      fetch_vector_ff <= `TEU_HANDLER_VEC;
    end
  end

endmodule : teu_trap_entry

//--- test/teu_pipe.sv
`timescale 1ns/10ps

module teu_pipe
  import teu_pkg::*;
(
  input wire logic core_clk,
  output teu_exec_type exec,
  output logic ext_intr_input,
  output logic bus_error_input,
  output logic parity_enable_input,
  output logic bus_read_parity_err
);
  // Start quiet so no cause is seen before the first request.
  initial begin
    exec = '0;
    ext_intr_input = 1'b0;
    bus_error_input = 1'b0;
    parity_enable_input = 1'b0;
    bus_read_parity_err = 1'b0;
  end

  // One instruction completes per call; back-to-back calls keep valid high.
  task automatic put(input teu_exec_type e);
    @(posedge core_clk);
    exec <= e;
  endtask : put

  // An idle slot shows a flipped address, so a stale value cannot pass.
  task automatic idle;
    teu_exec_type e;
    e = '0;
    e.pc = ~exec.pc;
    @(posedge core_clk);
    exec <= e;
  endtask : idle

  // Event pins stand two cycles, since the glitch filter drops a one-cycle pulse.
  task automatic pin(input int k);
    @(posedge core_clk);
    ext_intr_input <= (k == 1);
    bus_error_input <= (k == 2);
    repeat (2) @(posedge core_clk);
    ext_intr_input <= 1'b0;
    bus_error_input <= 1'b0;
  endtask : pin

  // The strobe waits until the enable pin has crossed the synchroniser.
  task automatic parity(input logic en);
    @(posedge core_clk);
    parity_enable_input <= en;
    repeat (6) @(posedge core_clk);
    bus_read_parity_err <= 1'b1;
    @(posedge core_clk);
    bus_read_parity_err <= 1'b0;
    parity_enable_input <= 1'b0;
  endtask : parity
endmodule : teu_pipe

//--- test/teu_trap_entry_properties.sv
`timescale 1ns/10ps
`include "teu_consts.svh"

module teu_trap_entry_props
  import teu_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire teu_exec_type exec,
  input wire logic bus_error_input,
  input wire teu_psr_type psr_ff,
  input wire teu_epsr_type epsr_ff,
  input wire teu_fsr_type fsr_ff,
  input wire logic [31:0] fir_ff,
  input wire logic trap_taken_ff,
  input wire logic restartable_ff,
  input wire logic [31:0] fetch_vector_ff,
  input wire logic force_single_ff,
  input wire logic fp_half_commit_ff,
  input wire logic fp_half_squash_ff
);
  // All checks share the core clock and stay quiet while reset is low.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  AST_VEC_FIXED: assert property (fetch_vector_ff == `TEU_HANDLER_VEC)
    else $error("handler vector moved");
  AST_SINGLE_START: assert property (force_single_ff == trap_taken_ff)
    else $error("single mode not forced with trap");
  AST_MODE_CLEAR: assert property (trap_taken_ff |-> !psr_ff.user_flag && !psr_ff.intr_mode_flag)
    else $error("mode bits not cleared");
  AST_PREV_SAVE: assert property (trap_taken_ff |-> psr_ff.prev_user_flag == $past(psr_ff.user_flag) &&
    psr_ff.prev_intr_flag == $past(psr_ff.intr_mode_flag)) else $error("previous mode not saved");
  AST_DUAL_REC: assert property (trap_taken_ff && $past(exec.valid) |->
    psr_ff.dual_mode_at_trap == $past(exec.dual_mode)) else $error("dual mode not recorded");
  AST_FIR_LOAD: assert property (trap_taken_ff && $past(exec.valid) |-> fir_ff == $past(exec.pc))
    else $error("fault address wrong");
  AST_SW_TRAP: assert property (exec.valid && exec.op_trap |=> trap_taken_ff && psr_ff.instr_fault_flag)
    else $error("trap instruction ignored");
  AST_TRAP_SQUASH: assert property (exec.valid && exec.op_trap && exec.dual_mode |=>
    fp_half_squash_ff && !fp_half_commit_ff) else $error("companion not squashed");
  AST_PIPE_TRAP: assert property (exec.valid && exec.uses_pipe && epsr_ff.pipe_trap_flag |=>
    trap_taken_ff && epsr_ff.pipe_in_use_flag) else $error("pipe use not trapped");
  AST_SRC_EXC: assert property (exec.valid && exec.src_exc && exec.fp_op inside {teu_fp_mult, teu_fp_add}
    |=> psr_ff.fp_fault_flag && fsr_ff.source_exc_flag) else $error("source exception missed");
  AST_BUS_ERROR_INPUT_TRAP: assert property ($rose(bus_error_input) |-> ##[3:8]
    (trap_taken_ff && epsr_ff.bus_error_flag && !restartable_ff)) else $error("bus error not trapped");
endmodule : teu_trap_entry_props

//--- test/trap_entry_unit_tb_top.sv
`timescale 1ns/10ps
`include "teu_consts.svh"

module trap_entry_unit_tb_top
  import teu_pkg::*;
;
  typedef struct packed {
    teu_psr_type p;
    teu_epsr_type e;
    teu_fsr_type f;
    logic [31:0] a, c;
    logic ap, r, cm, sq;
  } teu_note_type;
  localparam teu_psr_type k_if = 11'h010, k_ext = 11'h008, k_fch = 11'h004, k_dat = 11'h002, k_fp = 11'h001;
  logic core_clk, nrst, fp_trap_en, sw_psr_wr, sw_epsr_wr, sw_fsr_wr;
  logic bus_read_parity_err, parity_enable_input, bus_error_input, ext_intr_input;
  logic trap_taken_ff, restartable_ff, force_single_ff, fp_half_commit_ff, fp_half_squash_ff;
  logic [31:0] fir_ff, core_fault_addr_ff, fetch_vector_ff;
  teu_psr_type sw_psr_data, psr_ff;
  teu_epsr_type sw_epsr_data, epsr_ff;
  teu_fsr_type sw_fsr_data, fsr_ff, r;
  teu_exec_type exec, e;
  teu_note_type q[$];
  teu_note_type n;
  int mismatches, total_checks, tn;
  integer seed = 43;

  teu_pipe u_teu_pipe (.core_clk, .exec, .ext_intr_input, .bus_error_input, .parity_enable_input,
    .bus_read_parity_err);
  teu_trap_entry u_teu_trap_entry (.core_clk, .nrst, .exec, .fp_trap_en, .bus_read_parity_err,
    .parity_enable_input, .bus_error_input, .ext_intr_input, .sw_psr_wr, .sw_psr_data, .sw_epsr_wr,
    .sw_epsr_data, .sw_fsr_wr, .sw_fsr_data, .psr_ff, .epsr_ff, .fsr_ff, .fir_ff, .core_fault_addr_ff,
    .trap_taken_ff, .restartable_ff, .fetch_vector_ff, .force_single_ff, .fp_half_commit_ff, .fp_half_squash_ff);

  // Free-running core clock.
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_flag(input logic got, input logic exp);
    chk_word({31'h0000_0000, got}, {31'h0000_0000, exp});
  endtask : chk_flag

  // A valid instruction at an 8-byte aligned random address.
  function automatic teu_exec_type mk(input logic d, input logic nd);
    mk = '0;
    mk.valid = 1'b1;
    mk.pc = 32'($random(seed)) & 32'hFFFF_FFF8;
    mk.dual_mode = d;
    mk.next_dual = nd;
  endfunction : mk

  // Set a known status, note the expected entry, then run one kind of cause.
  task automatic go(input teu_exec_type e, input teu_epsr_type ep0, input teu_psr_type xp,
      input teu_epsr_type xe, input teu_fsr_type xf, input logic tr, input int mode);
    teu_psr_type p0;
    teu_note_type n0;
    teu_exec_type l;
    p0 = '0;
    p0.user_flag = 1'($random(seed));
    p0.intr_mode_flag = 1'b1;
    n0.p = xp;
    n0.p.prev_user_flag = p0.user_flag;
    n0.p.prev_intr_flag = 1'b1;
    n0.p.dual_mode_at_trap = e.dual_mode;
    n0.p.dual_switch_flag = e.dual_mode ^ e.next_dual;
    n0.e = ep0 | xe;
    n0.f = xf;
    n0.a = e.pc;
    n0.c = (e.dual_mode && (e.fetch_fault || e.data_fault)) ? e.pc + `TEU_CORE_HALF_OFS : e.pc;
    n0.ap = (mode == 0 || mode == 5);
    n0.r = !(xe.bus_error_flag || xe.parity_error_flag);
    n0.cm = e.dual_mode && (e.op_intovr || (e.data_fault && !e.op_trap && !e.fp_is_fxfr));
    n0.sq = e.dual_mode && !n0.cm;
    @(posedge core_clk);
    sw_psr_wr <= 1'b1;
    sw_epsr_wr <= 1'b1;
    sw_fsr_wr <= 1'b1;
    sw_psr_data <= p0;
    sw_epsr_data <= ep0;
    @(posedge core_clk);
    sw_psr_wr <= 1'b0;
    sw_epsr_wr <= 1'b0;
    sw_fsr_wr <= 1'b0;
    // A bus-error level that stands two cycles traps twice, the second time from supervisor mode.
    if (tr) begin
      q.push_back(n0);
      if (mode == 2) begin
        n0.p.prev_user_flag = 1'b0;
        n0.p.prev_intr_flag = 1'b0;
        q.push_back(n0);
      end
    end
    case (mode)
      0: u_teu_pipe.put(e);
      1, 2: u_teu_pipe.pin(mode);
      3, 4: u_teu_pipe.parity(mode == 3);
      default: begin
        for (int i = 0; i < 33; i++) begin
          l = e;
          l.op_lock = (i == 0);
          l.op_ldst = (i == 1) || (mode == 6 && i == 31);
          l.op_unlock = (i == 2);
          u_teu_pipe.put(l);
        end
      end
    endcase
    u_teu_pipe.idle();
    // Long enough for a pin cause to cross the synchroniser.
    repeat (12) @(posedge core_clk);
    tn++;
    if (q.size() != 0) begin
      chk_flag(1'b0, 1'b1);
      test_done();
    end
    $display("test %0d done", tn);
  endtask : go

  // Each trap pulse takes the oldest note; a pulse with none noted is wrong.
  always @(posedge core_clk) begin
    if (nrst === 1'b1 && trap_taken_ff === 1'b1) begin
      if (q.size() == 0) begin
        chk_flag(trap_taken_ff, 1'b0);
      end else begin
        n = q.pop_front();
        chk_word(32'(psr_ff), 32'(n.p));
        chk_word(32'(epsr_ff), 32'(n.e));
        chk_word(32'(fsr_ff), 32'(n.f));
        if (n.ap) begin
          chk_word(fir_ff, n.a);
          chk_word(core_fault_addr_ff, n.c);
        end
        chk_word(fetch_vector_ff, `TEU_HANDLER_VEC);
        chk_flag(restartable_ff, n.r);
        chk_flag(force_single_ff, 1'b1);
        chk_flag(fp_half_commit_ff, n.cm);
        chk_flag(fp_half_squash_ff, n.sq);
      end
    end
  end

  // Main sequence: reset, then one or more scenarios per cause.
  initial begin
    nrst = 1'b0;
    fp_trap_en = 1'b1;
    sw_psr_wr = 1'b0;
    sw_epsr_wr = 1'b0;
    sw_fsr_wr = 1'b0;
    sw_psr_data = '0;
    sw_epsr_data = '0;
    sw_fsr_data = '0;
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    e = mk(1'b0, 1'b0);
    e.op_trap = 1'b1;
    go(e, '0, k_if, '0, '0, 1'b1, 0);
    e = mk(1'b1, 1'b0);
    e.op_trap = 1'b1;
    go(e, '0, k_if, '0, '0, 1'b1, 0);
    e = mk(1'b1, 1'b1);
    e.op_intovr = 1'b1;
    go(e, 6'h20, k_if, '0, '0, 1'b1, 0);
    go(e, '0, k_if, '0, '0, 1'b0, 0);
    e = mk(1'b0, 1'b1);
    e.uses_pipe = 1'b1;
    go(e, 6'h04, k_if, 6'h08, '0, 1'b1, 0);
    e = mk(1'b1, 1'b1);
    e.data_fault = 1'b1;
    go(e, '0, k_dat, '0, '0, 1'b1, 0);
    e.fp_is_fxfr = 1'b1;
    go(e, '0, k_dat, '0, '0, 1'b1, 0);
    e = mk(1'b0, 1'b0);
    e.fetch_fault = 1'b1;
    go(e, '0, k_fch, '0, '0, 1'b1, 0);
    e = mk(1'b1, 1'b0);
    e.op_trap = 1'b1;
    e.data_fault = 1'b1;
    go(e, '0, k_if | k_dat, '0, '0, 1'b1, 0);
    // Every unit operation, with source and then result exceptions.
    for (int op = 1; op < 6; op++) begin
      e = mk(1'b0, 1'b0);
      e.fp_op = teu_fpop_type'(op);
      e.src_exc = 1'b1;
      go(e, '0, k_fp, '0, 7'h40, op != 3, 0);
      r = (7'($random(seed)) & 7'h3F) | 7'h01;
      e.src_exc = 1'b0;
      e.res_exc = r;
      go(e, '0, k_fp, '0, r, op < 3, 0);
    end
    fp_trap_en <= 1'b0;
    e.fp_op = teu_fp_mult;
    go(e, '0, k_fp, '0, r, 1'b0, 0);
    fp_trap_en <= 1'b1;
    go('0, '0, k_ext, '0, '0, 1'b1, 1);
    go('0, '0, k_ext, 6'h02, '0, 1'b1, 2);
    go('0, '0, k_ext, 6'h01, '0, 1'b1, 3);
    go('0, '0, k_ext, 6'h01, '0, 1'b0, 4);
    e = mk(1'b0, 1'b0);
    go(e, '0, k_if, 6'h10, '0, 1'b1, 5);
    go(e, '0, k_if, 6'h10, '0, 1'b0, 6);
    test_done();
  end
endmodule : trap_entry_unit_tb_top

bind teu_trap_entry teu_trap_entry_props u_teu_trap_entry_props (.core_clk, .nrst, .exec, .bus_error_input,
  .psr_ff, .epsr_ff, .fsr_ff, .fir_ff, .trap_taken_ff, .restartable_ff, .fetch_vector_ff, .force_single_ff,
  .fp_half_commit_ff, .fp_half_squash_ff);
